// File: src/cfiu_pkg.sv
// Purpose: Shared constants and carrier types for the CAN interrupt flag unit.
// Assumes: 32 mailboxes, two interrupt lines, 8-bit error counters.
// Notes: Global mask bits for the system flags sit at the same positions as the flags.
package cfiu_pkg;

    localparam int MBX_COUNT = 32;
    localparam int VEC_W = 5;
    localparam int ERR_CNT_W = 8;

    // Error counter threshold for the warning level flag
    localparam logic [ERR_CNT_W-1:0] WARN_LIMIT = 8'h60;

    // Global flag register field positions
    localparam int FLG_VEC_LSB = 0;
    localparam int FLG_WARN = 8;
    localparam int FLG_EPASS = 9;
    localparam int FLG_BUSOFF = 10;
    localparam int FLG_RXLOST = 11;
    localparam int FLG_WAKE = 12;
    localparam int FLG_WDENY = 13;
    localparam int FLG_ABORT = 14;
    localparam int FLG_MBX = 15;
    localparam int FLG_TSOVF = 16;
    localparam int FLG_MTO = 17;

    // Global mask register bit positions
    localparam int GM_LINE0_EN = 0;
    localparam int GM_LINE1_EN = 1;
    localparam int GM_SYS_LINE = 2;
    localparam int GM_WARN = 8;
    localparam int GM_EPASS = 9;
    localparam int GM_BUSOFF = 10;
    localparam int GM_RXLOST = 11;
    localparam int GM_WAKE = 12;
    localparam int GM_WDENY = 13;
    localparam int GM_ABORT = 14;
    localparam int GM_TSOVF = 16;
    localparam int GM_MTO = 17;

    // Index of each write-one-to-clear system flag in the sticky vector
    localparam int SYS_WARN = 0;
    localparam int SYS_EPASS = 1;
    localparam int SYS_BUSOFF = 2;
    localparam int SYS_WAKE = 3;
    localparam int SYS_WDENY = 4;
    localparam int SYS_TSOVF = 5;
    localparam int SYS_N = 6;

    localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
    localparam logic [SYS_N-1:0] SYS_RESET = 6'h00;
    localparam logic [MBX_COUNT-1:0] MBX_RESET = 32'h0000_0000;

    // Per-mailbox status bits as kept by the mailbox logic
    typedef struct packed {
        logic [MBX_COUNT-1:0] in_use;
        logic [MBX_COUNT-1:0] tx_ack_bits;
        logic [MBX_COUNT-1:0] rx_pending_bits;
        logic [MBX_COUNT-1:0] timeout_status_bits;
        logic [MBX_COUNT-1:0] abort_ack_bits;
        logic [MBX_COUNT-1:0] rx_lost_bits;
    } cfiu_mbx_stat_t;

    // Protocol engine status
    typedef struct packed {
        logic [ERR_CNT_W-1:0] tx_err_cnt;
        logic [ERR_CNT_W-1:0] rx_err_cnt;
        logic error_passive;
        logic bus_off;
        logic power_down;
        logic write_denied;
        logic timestamp_msb;
    } cfiu_sys_stat_t;

    // Interrupt configuration
    typedef struct packed {
        logic [31:0] global_irq_mask;
        logic [MBX_COUNT-1:0] mailbox_level_select;
        logic [MBX_COUNT-1:0] mailbox_irq_mask;
    } cfiu_cfg_t;

    // Software write to one global flag register
    typedef struct packed {
        logic line0_we;
        logic line1_we;
        logic [31:0] data;
    } cfiu_clr_t;

endpackage

// File: src/cfiu_mbx_scan.sv
// Purpose: Finds pending mailbox events for one line and the highest such mailbox.
// Assumes: Inputs are stable within a cycle; result is registered by the caller.
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module cfiu_mbx_scan (
    input wire logic [cfiu_pkg::MBX_COUNT-1:0] pending_in,
    output logic any_out,
    output logic [cfiu_pkg::VEC_W-1:0] vector_out
);
    import cfiu_pkg::*;

    // Highest set index wins, so the loop runs upward and overwrites
    function automatic logic [VEC_W-1:0] top_index(input logic [MBX_COUNT-1:0] v);
        logic [VEC_W-1:0] idx;
        idx = '0;
        for (int i = 0; i < MBX_COUNT; i++) begin
            if (v[i]) begin
                idx = VEC_W'(i);
            end
        end
        return idx;
    endfunction

    // Reduction and vector
    always_comb begin
        any_out = |pending_in;
        vector_out = top_index(pending_in);
    end

endmodule // cfiu_mbx_scan
`default_nettype wire

// File: src/cfiu_flag_unit.sv
// Purpose: Collects CAN system and mailbox events into two global flag words and two lines.
// Assumes: All inputs synchronous to mclk_in; mailbox status bits kept by the mailbox logic.
// Notes: Mailbox-derived flags follow their source bits; system flags are write-one-to-clear.
//
// Function
// - An active line stays up until flags clear; drops only with nothing pending.
// - System flags go to line-1 word when system line select is one.
// - Mailbox event and timeout flags follow that mailbox's line select bit.
// - Warning flag sets when either error counter reaches 96; written one clears.
// - Error-passive and bus-off flags set on entering those states; written one clears.
// - Wake-up flag sets on leaving local power-down; written one clears.
// - Write-denied flag sets on a refused mailbox write; written one clears.
// - Timestamp overflow flag sets on counter MSB rising; written one clears.
// - For these six flags writing one clears, writing zero keeps.
// - Mailbox event flag clears only through transmit-ack or receive-pending bits.
// - Mailbox timeout flag clears when the timeout status bit clears.
// - Abort-acknowledge flag clears when its causing abort-ack bit clears.
// - Receive-lost flag clears when overwritten mailbox's receive-pending bit clears.
// - Mailbox event flag sits in bit 15 of each flag word.
// - While mailbox event set, bits 4-0 show the interrupting mailbox number.
// - Abort-acknowledge flag at bit 14, receive-lost flag at bit 11.
// - A receive-lost event also raises the mailbox event flag.
// - Per-mailbox level bit picks line 0 or line 1 for that mailbox.
// - Mailbox mask gates mailbox events; unused mailboxes raise no event or timeout flag.
// - Line enables at mask bits 1 and 0, receive-lost mask bit 11.
// - With several mailboxes pending, the vector shows the highest-numbered one.
// - A new flag drives a line only if its mask bit is set.
`timescale 1ns/1ps
`default_nettype none
module cfiu_flag_unit (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire cfiu_pkg::cfiu_cfg_t cfg_in,
    input wire cfiu_pkg::cfiu_mbx_stat_t mbx_in,
    input wire cfiu_pkg::cfiu_sys_stat_t sys_in,
    input wire cfiu_pkg::cfiu_clr_t clr_in,
    output logic [31:0] global_flags_line0_out,
    output logic [31:0] global_flags_line1_out,
    output logic irq_line0_out,
    output logic irq_line1_out
);
    import cfiu_pkg::*;

    // Edge history of level-type sources
    logic warn_lvl_q;
    logic epass_lvl_q;
    logic busoff_lvl_q;
    logic pdown_lvl_q;
    logic tsmsb_lvl_q;
    logic [MBX_COUNT-1:0] abort_prev_q;
    logic [MBX_COUNT-1:0] rxlost_prev_q;

    // Sticky system flags, one vector per line
    logic [SYS_N-1:0] sys0_q;
    logic [SYS_N-1:0] sys0_d;
    logic [SYS_N-1:0] sys1_q;
    logic [SYS_N-1:0] sys1_d;

    // Mailboxes whose abort or overwrite set a flag on each line
    logic [MBX_COUNT-1:0] abort_src0_q;
    logic [MBX_COUNT-1:0] abort_src0_d;
    logic [MBX_COUNT-1:0] abort_src1_q;
    logic [MBX_COUNT-1:0] abort_src1_d;
    logic [MBX_COUNT-1:0] lost_src0_q;
    logic [MBX_COUNT-1:0] lost_src0_d;
    logic [MBX_COUNT-1:0] lost_src1_q;
    logic [MBX_COUNT-1:0] lost_src1_d;

    // Combinational terms
    logic warn_now;
    logic sys_line;
    logic [SYS_N-1:0] sys_set;
    logic [MBX_COUNT-1:0] abort_rise;
    logic [MBX_COUNT-1:0] lost_rise;
    logic [MBX_COUNT-1:0] mbx_live;
    logic [MBX_COUNT-1:0] mbx_evt;
    logic [MBX_COUNT-1:0] mbx_evt0;
    logic [MBX_COUNT-1:0] mbx_evt1;
    logic [MBX_COUNT-1:0] mto0;
    logic [MBX_COUNT-1:0] mto1;
    logic mbx_any0;
    logic mbx_any1;
    logic [VEC_W-1:0] vec0;
    logic [VEC_W-1:0] vec1;
    logic [31:0] flags0_d;
    logic [31:0] flags1_d;
    logic irq0_d;
    logic irq1_d;

    // Assemble one flag word from its parts
    function automatic logic [31:0] pack_flags(
        input logic [SYS_N-1:0] sys,
        input logic mbx_any,
        input logic [VEC_W-1:0] vec,
        input logic abort_any,
        input logic lost_any,
        input logic mto_any
    );
        logic [31:0] w;
        w = FLAGS_RESET;
        w[FLG_WARN] = sys[SYS_WARN];
        w[FLG_EPASS] = sys[SYS_EPASS];
        w[FLG_BUSOFF] = sys[SYS_BUSOFF];
        w[FLG_WAKE] = sys[SYS_WAKE];
        w[FLG_WDENY] = sys[SYS_WDENY];
        w[FLG_TSOVF] = sys[SYS_TSOVF];
        w[FLG_MBX] = mbx_any;
        w[FLG_ABORT] = abort_any;
        w[FLG_RXLOST] = lost_any;
        w[FLG_MTO] = mto_any;
        if (mbx_any) begin
            w[FLG_VEC_LSB +: VEC_W] = vec;
        end
        return w;
    endfunction

    // One line's request: every set flag gated by its mask and the line enable
    function automatic logic line_request(
        input logic [31:0] w,
        input logic [31:0] gm,
        input logic line_en
    );
        logic any;
        any = w[FLG_MBX]; // mailbox mask already applied per mailbox
        any = any | (w[FLG_WARN] & gm[GM_WARN]);
        any = any | (w[FLG_EPASS] & gm[GM_EPASS]);
        any = any | (w[FLG_BUSOFF] & gm[GM_BUSOFF]);
        any = any | (w[FLG_WAKE] & gm[GM_WAKE]);
        any = any | (w[FLG_WDENY] & gm[GM_WDENY]);
        any = any | (w[FLG_TSOVF] & gm[GM_TSOVF]);
        any = any | (w[FLG_ABORT] & gm[GM_ABORT]);
        any = any | (w[FLG_RXLOST] & gm[GM_RXLOST]);
        any = any | (w[FLG_MTO] & gm[GM_MTO]);
        return any & line_en;
    endfunction

    // Event detection on the system sources
    always_comb begin
        warn_now = (sys_in.tx_err_cnt >= WARN_LIMIT) || (sys_in.rx_err_cnt >= WARN_LIMIT);
        sys_line = cfg_in.global_irq_mask[GM_SYS_LINE];
        sys_set = SYS_RESET;
        sys_set[SYS_WARN] = warn_now & ~warn_lvl_q;
        sys_set[SYS_EPASS] = sys_in.error_passive & ~epass_lvl_q;
        sys_set[SYS_BUSOFF] = sys_in.bus_off & ~busoff_lvl_q;
        sys_set[SYS_WAKE] = ~sys_in.power_down & pdown_lvl_q;
        sys_set[SYS_WDENY] = sys_in.write_denied;
        sys_set[SYS_TSOVF] = sys_in.timestamp_msb & ~tsmsb_lvl_q;
    end

    // Sticky system flags: set beats a simultaneous write-one clear
    always_comb begin
        sys0_d = sys0_q;
        sys1_d = sys1_q;
        if (clr_in.line0_we) begin
            sys0_d = sys0_d & ~{clr_in.data[FLG_TSOVF], clr_in.data[FLG_WDENY],
                clr_in.data[FLG_WAKE], clr_in.data[FLG_BUSOFF],
                clr_in.data[FLG_EPASS], clr_in.data[FLG_WARN]};
        end
        if (clr_in.line1_we) begin
            sys1_d = sys1_d & ~{clr_in.data[FLG_TSOVF], clr_in.data[FLG_WDENY],
                clr_in.data[FLG_WAKE], clr_in.data[FLG_BUSOFF],
                clr_in.data[FLG_EPASS], clr_in.data[FLG_WARN]};
        end
        if (sys_line) begin
            sys1_d = sys1_d | sys_set;
        end else begin
            sys0_d = sys0_d | sys_set;
        end
    end

    // Abort and overwrite sources; flags fall with their mailbox bits, not with writes
    always_comb begin
        abort_rise = mbx_in.abort_ack_bits & ~abort_prev_q;
        lost_rise = mbx_in.rx_lost_bits & ~rxlost_prev_q;
        abort_src0_d = abort_src0_q & mbx_in.abort_ack_bits;
        abort_src1_d = abort_src1_q & mbx_in.abort_ack_bits;
        lost_src0_d = lost_src0_q & mbx_in.rx_pending_bits;
        lost_src1_d = lost_src1_q & mbx_in.rx_pending_bits;
        if (sys_line) begin
            abort_src1_d = abort_src1_d | abort_rise;
            lost_src1_d = lost_src1_d | (lost_rise & mbx_in.rx_pending_bits);
        end else begin
            abort_src0_d = abort_src0_d | abort_rise;
            lost_src0_d = lost_src0_d | (lost_rise & mbx_in.rx_pending_bits);
        end
    end

    // Mailbox events follow the status bits directly, split by level select
    always_comb begin
        mbx_live = mbx_in.in_use & cfg_in.mailbox_irq_mask;
        // Overwritten mailbox keeps receive-pending set, so it shows here too
        mbx_evt = (mbx_in.tx_ack_bits | mbx_in.rx_pending_bits) & mbx_live;
        mbx_evt0 = mbx_evt & ~cfg_in.mailbox_level_select;
        mbx_evt1 = mbx_evt & cfg_in.mailbox_level_select;
        mto0 = mbx_in.timeout_status_bits & mbx_in.in_use & ~cfg_in.mailbox_level_select;
        mto1 = mbx_in.timeout_status_bits & mbx_in.in_use & cfg_in.mailbox_level_select;
    end

    // Highest pending mailbox per line
    cfiu_mbx_scan u_scan0 (
        .pending_in(mbx_evt0),
        .any_out(mbx_any0),
        .vector_out(vec0)
    );

    cfiu_mbx_scan u_scan1 (
        .pending_in(mbx_evt1),
        .any_out(mbx_any1),
        .vector_out(vec1)
    );

    // Next flag words and line requests
    always_comb begin
        flags0_d = pack_flags(sys0_d, mbx_any0, vec0, |abort_src0_d, |lost_src0_d, |mto0);
        flags1_d = pack_flags(sys1_d, mbx_any1, vec1, |abort_src1_d, |lost_src1_d, |mto1);
        irq0_d = line_request(flags0_d, cfg_in.global_irq_mask,
            cfg_in.global_irq_mask[GM_LINE0_EN]);
        irq1_d = line_request(flags1_d, cfg_in.global_irq_mask,
            cfg_in.global_irq_mask[GM_LINE1_EN]);
    end

    // Source history for edge detection
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            warn_lvl_q <= 1'b0;
            epass_lvl_q <= 1'b0;
            busoff_lvl_q <= 1'b0;
            pdown_lvl_q <= 1'b0;
            tsmsb_lvl_q <= 1'b0;
            abort_prev_q <= MBX_RESET;
            rxlost_prev_q <= MBX_RESET;
        end else begin
            warn_lvl_q <= warn_now;
            epass_lvl_q <= sys_in.error_passive;
            busoff_lvl_q <= sys_in.bus_off;
            pdown_lvl_q <= sys_in.power_down;
            tsmsb_lvl_q <= sys_in.timestamp_msb;
            abort_prev_q <= mbx_in.abort_ack_bits;
            rxlost_prev_q <= mbx_in.rx_lost_bits;
        end
    end

    // Sticky system flag state
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            sys0_q <= SYS_RESET;
            sys1_q <= SYS_RESET;
        end else begin
            sys0_q <= sys0_d;
            sys1_q <= sys1_d;
        end
    end

    // Abort and overwrite source state
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            abort_src0_q <= MBX_RESET;
            abort_src1_q <= MBX_RESET;
            lost_src0_q <= MBX_RESET;
            lost_src1_q <= MBX_RESET;
        end else begin
            abort_src0_q <= abort_src0_d;
            abort_src1_q <= abort_src1_d;
            lost_src0_q <= lost_src0_d;
            lost_src1_q <= lost_src1_d;
        end
    end

    // Registered outputs; line holds while anything unmasked stays pending
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            global_flags_line0_out <= FLAGS_RESET;
            global_flags_line1_out <= FLAGS_RESET;
            irq_line0_out <= 1'b0;
            irq_line1_out <= 1'b0;
        end else begin
            global_flags_line0_out <= flags0_d;
            global_flags_line1_out <= flags1_d;
            irq_line0_out <= irq0_d;
            irq_line1_out <= irq1_d;
        end
    end

endmodule // cfiu_flag_unit
`default_nettype wire

// File: dv/cfiu_flag_unit_properties.sv
// Purpose: Concurrent checks on the CAN interrupt flag unit ports.
// Assumes: One clock; flag words and lines lag their causes by one edge.
// Notes: Registered input copies stand in for last-cycle causes.
`timescale 1ns/1ps
`default_nettype none
module cfiu_flag_unit_properties (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire cfiu_pkg::cfiu_cfg_t cfg_in,
    input wire cfiu_pkg::cfiu_mbx_stat_t mbx_in,
    input wire cfiu_pkg::cfiu_sys_stat_t sys_in,
    input wire cfiu_pkg::cfiu_clr_t clr_in,
    input wire logic [31:0] global_flags_line0_out,
    input wire logic [31:0] global_flags_line1_out,
    input wire logic irq_line0_out,
    input wire logic irq_line1_out
);
    import cfiu_pkg::*;
    logic [31:0] f0, f1, gm, hit;
    logic rst_q;
    logic [31:0] gm_q, pend0_q, pend1_q, mto1_q, abort_q, rxp_q;
    // Short aliases
    assign f0 = global_flags_line0_out;
    assign f1 = global_flags_line1_out;
    assign gm = cfg_in.global_irq_mask;
    assign hit = (mbx_in.tx_ack_bits | mbx_in.rx_pending_bits) & mbx_in.in_use
        & cfg_in.mailbox_irq_mask;
    // Last cycle's causes; the reset copy hides the first edge after release
    always_ff @(posedge mclk_in) begin
        rst_q <= sys_rst_in;
        gm_q <= gm;
        pend0_q <= hit & ~cfg_in.mailbox_level_select;
        pend1_q <= hit & cfg_in.mailbox_level_select;
        mto1_q <= mbx_in.timeout_status_bits & mbx_in.in_use & cfg_in.mailbox_level_select;
        abort_q <= mbx_in.abort_ack_bits;
        rxp_q <= mbx_in.rx_pending_bits;
    end
    // Highest set index of a mailbox vector
    function automatic logic [4:0] top_idx(input logic [31:0] v);
        top_idx = 5'h00;
        for (int i = 0; i < 32; i++) begin
            if (v[i]) begin
                top_idx = i[4:0];
            end
        end
    endfunction
    // Any set flag whose mask lets it reach the line; bit 15 has no global mask
    function automatic logic live(input logic [31:0] f, input logic [31:0] m);
        live = |(f[17:8] & {m[17:16], 1'b1, m[14:8]});
    endfunction
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    a_line0_level: assert property (
        irq_line0_out == (gm_q[GM_LINE0_EN] && live(f0, gm_q)))
        else $error("line 0 disagrees with its flags and masks");
    a_line1_level: assert property (
        irq_line1_out == (gm_q[GM_LINE1_EN] && live(f1, gm_q)))
        else $error("line 1 disagrees with its flags and masks");
    a_busoff_set: assert property (
        $rose(sys_in.bus_off) && !gm[GM_SYS_LINE] |=> f0[FLG_BUSOFF])
        else $error("bus-off entry did not set its flag");
    a_warn_set: assert property (
        $rose(sys_in.tx_err_cnt >= WARN_LIMIT || sys_in.rx_err_cnt >= WARN_LIMIT)
        && gm[GM_SYS_LINE] |=> f1[FLG_WARN])
        else $error("warning level did not set its flag");
    a_wake_set: assert property (
        !rst_q && $fell(sys_in.power_down) && !gm[GM_SYS_LINE] |=> f0[FLG_WAKE])
        else $error("leaving power-down did not set the wake flag");
    a_zero_keeps: assert property (
        clr_in.line0_we && !clr_in.data[FLG_EPASS] && f0[FLG_EPASS] |=> f0[FLG_EPASS])
        else $error("writing zero lost the error-passive flag");
    a_one_clears: assert property (
        !rst_q && clr_in.line1_we && clr_in.data[FLG_BUSOFF] && !$rose(sys_in.bus_off)
        |=> !f1[FLG_BUSOFF])
        else $error("writing one did not clear the bus-off flag");
    a_mbx_follow: assert property (
        !rst_q |-> f0[FLG_MBX] == (|pend0_q))
        else $error("mailbox event flag does not follow its sources");
    a_vec_top: assert property (
        !rst_q && f1[FLG_MBX] |-> f1[4:0] == top_idx(pend1_q))
        else $error("vector is not the highest pending mailbox");
    a_mto_follow: assert property (
        !rst_q && gm_q[GM_MTO] |-> f1[FLG_MTO] == (|mto1_q))
        else $error("timeout flag does not follow the timeout bits");
    a_abort_drop: assert property (
        !rst_q && abort_q == 32'h0000_0000 |-> !f0[FLG_ABORT] && !f1[FLG_ABORT])
        else $error("abort flag stayed with no abort bit set");
    a_lost_drop: assert property (
        !rst_q && rxp_q == 32'h0000_0000 |-> !f0[FLG_RXLOST] && !f1[FLG_RXLOST])
        else $error("lost flag stayed with no pending bit set");
    c_both_lines: cover property (irq_line0_out && irq_line1_out);
    c_clear_write: cover property (clr_in.line0_we && f0[FLG_BUSOFF]);
    c_vector: cover property (f1[FLG_MBX] && f1[4:0] != 5'h00);
endmodule // cfiu_flag_unit_properties
bind cfiu_flag_unit cfiu_flag_unit_properties i_props (.mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in), .cfg_in(cfg_in), .mbx_in(mbx_in), .sys_in(sys_in),
    .clr_in(clr_in), .global_flags_line0_out(global_flags_line0_out),
    .global_flags_line1_out(global_flags_line1_out), .irq_line0_out(irq_line0_out),
    .irq_line1_out(irq_line1_out));
`default_nettype wire

// File: dv/cfiu_cpu_model.sv
// Purpose: Behavioural interrupt handler serving the two flag-unit lines.
// Assumes: Mode 0 idle, 1 proper service, 2 a wrong write pattern.
// Notes: Service waits a programmable number of cycles to act slow or prompt.
`timescale 1ns/1ps
`default_nettype none
module cfiu_cpu_model (
    input wire logic mclk_in,
    input wire logic [1:0] irq_in,
    input wire logic [31:0] flags0_in,
    input wire logic [31:0] flags1_in,
    input wire logic [1:0] mode_in,
    input wire logic [3:0] delay_in,
    output var cfiu_pkg::cfiu_clr_t clr_out
);
    import cfiu_pkg::*;
    localparam logic [31:0] W1C = 32'h0001_3700;
    cfiu_clr_t clr_q = '0;
    logic [3:0] wait_q = 4'h0;
    assign clr_out = clr_q;
    // One write strobe per service, then rearm
    always_ff @(posedge mclk_in) begin
        clr_q <= '0;
        if (mode_in == 2'h0 || irq_in == 2'h0) begin
            wait_q <= 4'h0;
        end else if (wait_q < delay_in) begin
            wait_q <= wait_q + 4'h1;
        end else begin
            wait_q <= 4'h0;
            clr_q.line0_we <= irq_in[0];
            clr_q.line1_we <= irq_in[1];
            clr_q.data <= (mode_in == 2'h1) ? ((flags0_in | flags1_in) & W1C) : ~W1C;
        end
    end
endmodule // cfiu_cpu_model
`default_nettype wire

// File: dv/cfiu_flag_unit_tb_top.sv
// Purpose: Self-checking bench for the CAN interrupt flag unit.
// Assumes: Outputs follow inputs one edge later.
// Notes: Notes queue up with their cycle; a watcher checks them.
`timescale 1ns/1ps
`default_nettype none
module cfiu_flag_unit_tb_top;
    import cfiu_pkg::*;
    typedef struct packed {
        logic [31:0] t;
        logic [31:0] f0;
        logic [31:0] f1;
        logic [1:0] irq;
    } cfiu_note_t;
    localparam int POS [6] = '{FLG_WARN, FLG_EPASS, FLG_BUSOFF, FLG_WAKE, FLG_WDENY, FLG_TSOVF};
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    cfiu_cfg_t cfg = {32'h0003_7f03, 32'h0010_0008, 32'hffff_ffdf};
    cfiu_mbx_stat_t mbx = {32'hffff_ffbf, 160'h0};
    cfiu_sys_stat_t sys = 21'h00004;
    cfiu_clr_t clr;
    logic [31:0] f0, f1;
    logic [1:0] irq;
    logic [1:0] pm = 2'h0;
    logic [3:0] dly = 4'h0;
    logic [31:0] cyc = 32'h0;
    integer seed = 32;
    integer failures = 0;
    integer cmp_count = 0;
    cfiu_note_t q[$];
    cfiu_note_t n;
    cfiu_flag_unit i_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .cfg_in(cfg),
        .mbx_in(mbx), .sys_in(sys), .clr_in(clr), .global_flags_line0_out(f0),
        .global_flags_line1_out(f1), .irq_line0_out(irq[0]), .irq_line1_out(irq[1]));
    cfiu_cpu_model i_cpu (.mclk_in(mclk_in), .irq_in(irq), .flags0_in(f0),
        .flags1_in(f1), .mode_in(pm), .delay_in(dly), .clr_out(clr));
    // 40 MHz clock
    initial begin
        forever #12.5 mclk_in = ~mclk_in;
    end
    task automatic check(input logic [65:0] seen, input logic [65:0] want);
        cmp_count++;
        if (seen !== want) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic conclude();
        if (failures == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Note the outputs due one edge after this cycle's drive
    task automatic expect_out(input logic [31:0] e0, input logic [31:0] e1,
        input logic [1:0] ei);
        q.push_back('{cyc, e0, e1, ei});
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge mclk_in);
    endtask
    // Idle sources; receive count is random, anywhere below the warning threshold
    task automatic calm();
        @(posedge mclk_in);
        sys <= {8'h00, 8'({$random(seed)} % 96), 5'b00100};
    endtask
    task automatic fire(input int k);
        @(posedge mclk_in);
        case (k)
            0: sys.tx_err_cnt <= WARN_LIMIT;
            1: sys.error_passive <= 1'b1;
            2: sys.bus_off <= 1'b1;
            3: sys.power_down <= 1'b0;
            4: sys.write_denied <= 1'b1;
            default: sys.timestamp_msb <= 1'b1;
        endcase
    endtask
    // Handler clears what it may; the unit must then go quiet
    task automatic drain();
        int w;
        w = 0;
        pm <= 2'h1;
        while (irq !== 2'h0 && w < 40) begin
            @(posedge mclk_in);
            w++;
        end
        expect_out(32'h0, 32'h0, 2'h0);
        pm <= 2'h0;
    endtask
    // Oldest note is compared once its edge has passed
    always @(negedge mclk_in) begin
        if (q.size() > 0 && q[0].t + 32'h1 < cyc) begin
            n = q.pop_front();
            check({f0, f1, irq}, {n.f0, n.f1, n.irq});
        end
    end
    // Cycle count doubles as the hang limit
    always @(posedge mclk_in) begin
        cyc <= cyc + 32'h1;
        if (cyc == 32'd5000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        logic [31:0] acc;
        tick(20);
        sys_rst_in <= 1'b0;
        // Every system event on each line, a wrong write, then service
        for (int l = 0; l < 2; l++) begin
            acc = 32'h0;
            @(posedge mclk_in);
            cfg.global_irq_mask[GM_SYS_LINE] <= l[0];
            dly <= l[0] ? 4'h1 : 4'h8;
            for (int k = 0; k < 6; k++) begin
                fire(k);
                acc[POS[k]] = 1'b1;
                expect_out(l[0] ? 32'h0 : acc, l[0] ? acc : 32'h0, l[0] ? 2'h2 : 2'h1);
                calm();
            end
            pm <= 2'h2;
            tick(12);
            expect_out(l[0] ? 32'h0 : acc, l[0] ? acc : 32'h0, l[0] ? 2'h2 : 2'h1);
            drain();
        end
        // A masked flag sets its bit but leaves the line low until unmasked
        @(posedge mclk_in);
        cfg.global_irq_mask <= 32'h0003_7b03;
        fire(2);
        expect_out(32'h0000_0400, 32'h0, 2'h0);
        calm();
        cfg.global_irq_mask <= 32'h0003_7f03;
        expect_out(32'h0000_0400, 32'h0, 2'h1);
        tick(2);
        drain();
        // Mailbox 5 masked and 6 unused never show up
        @(posedge mclk_in);
        mbx.tx_ack_bits <= 32'h0000_0008;
        mbx.rx_pending_bits <= 32'h0010_00e0;
        expect_out(32'h0000_8007, 32'h0000_8014, 2'h3);
        @(posedge mclk_in);
        mbx.rx_pending_bits <= 32'h0000_00e0;
        expect_out(32'h0000_8007, 32'h0000_8003, 2'h3);
        @(posedge mclk_in);
        mbx.tx_ack_bits <= 32'h0;
        mbx.abort_ack_bits <= 32'h0000_0200;
        mbx.rx_lost_bits <= 32'h0000_0080;
        mbx.timeout_status_bits <= 32'h0010_0000;
        expect_out(32'h0000_c807, 32'h0002_0000, 2'h3);
        pm <= 2'h2;
        tick(6);
        expect_out(32'h0000_c807, 32'h0002_0000, 2'h3);
        pm <= 2'h0;
        @(posedge mclk_in);
        mbx.rx_pending_bits <= 32'h0000_0060;
        mbx.abort_ack_bits <= 32'h0;
        mbx.timeout_status_bits <= 32'h0;
        expect_out(32'h0, 32'h0, 2'h0);
        tick(3);
        // Random traffic for the concurrent checks
        pm <= 2'h1;
        repeat (300) begin
            @(posedge mclk_in);
            cfg <= {$random(seed), $random(seed), $random(seed)};
            mbx <= {$random(seed), $random(seed), $random(seed), $random(seed),
                $random(seed), $random(seed)};
            sys <= 21'($random(seed));
            dly <= 4'($random(seed));
        end
        tick(4);
        conclude();
    end
endmodule // cfiu_flag_unit_tb_top
`default_nettype wire
